// [rtl/bms_pkg.sv]
/*
 * Constants for the boot mode select block: register offsets, field positions,
 * sizes, fixed values and the mode and download state names.
 * Assumes a single 25 MHz system clock and a 32-bit Avalon-MM register port.
 */
// Operation
// R1: Boot ROM mapped only while enable bit set
// R2: Enable writable only in special modes
// R3: Expanded select loads strap A at release
// R4: Expanded select picks single-chip or expanded
// R5: Special select loads inverted strap B
// R6: Special select picks normal or special
// R7: Mode bits writable only in special modes
// R8: Special modes force A14 low on vectors
// R9: Reset sets enable only in bootstrap
// R10: Test mode accepts software enable write
// R11: Bootstrap reset vector comes from boot ROM
// R12: Test mode reset vector is external
// R13: Boot ROM is 192 or 448 bytes
// R14: First all-ones character picks baud rate
// R15: Received program stored in RAM, then run
// R16: Straps ignored after reset release
package bms_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [3:0] BMS_PRIO_OFS = 4'h0;
    localparam logic [3:0] BMS_STATUS_OFS = 4'h4;
    localparam logic [3:0] BMS_ROMADDR_OFS = 4'h8;
    localparam logic [3:0] BMS_ROMDATA_OFS = 4'hC;

    // ==========================================================
    // Field positions in the priority/mode register
    // ==========================================================
    localparam int BMS_EXP_BIT = 5;
    localparam int BMS_SPC_BIT = 6;
    localparam int BMS_BOOT_BIT = 7;

    // ==========================================================
    // Sizes and values
    // ==========================================================
    localparam int BMS_ROM_BASIC = 192;
    localparam int BMS_ROM_EXT = 448;
    localparam logic [7:0] BMS_FIRST_CHAR = 8'hFF;
    localparam logic [15:0] BMS_ROM_BASE = 16'hBF40;
    localparam logic [31:0] BMS_BAD_ADDR = 32'hDEADBEEF;

    // Mode names
    typedef enum logic [1:0]
    {
        BMS_NORM_SINGLE,
        BMS_NORM_EXP,
        BMS_BOOTSTRAP,
        BMS_TEST
    } bms_mode_e;

    // Bootstrap download sequence
    typedef enum logic [1:0]
    {
        BMS_WAIT_FIRST,
        BMS_LOADING,
        BMS_RUN
    } bms_boot_e;

endpackage

// [rtl/bms_rom_if.sv]
/*
 * Boot ROM access interface: address, request and registered data.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface bms_rom_if #(parameter int AW = 9);
    logic [AW-1:0] addr;
    logic rd;
    logic [7:0] data;
    modport user (output addr, output rd, input data);
    modport rom (input addr, input rd, output data);
endinterface

// [rtl/bms_boot_rom.sv]
/*
 * Small boot ROM with registered read data.
 * Assumes the contents are a constant pattern until firmware is supplied.
 */
`timescale 1ns/1ps
module bms_boot_rom #(
    parameter int DEPTH = bms_pkg::BMS_ROM_BASIC,
    parameter int AW = 9
)
(
    // Clock
    input wire logic sys_clk,
    // Access
    bms_rom_if.rom bus
);
    import bms_pkg::*;

    typedef struct packed
    {
        logic [7:0] data;
    } bms_rom_s;

    bms_rom_s st_q;
    bms_rom_s st_d;

    // ==========================================================
    // Read path
    // ==========================================================
    // Constant pattern; out-of-range reads give all ones
    always_comb
    begin
        st_d = st_q;
        if (bus.rd)
        begin
            if (int'(bus.addr) < DEPTH) // R13
                st_d.data = bus.addr[7:0] ^ 8'hA5;
            else
                st_d.data = 8'hFF;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    assign bus.data = st_q.data;

endmodule

// [rtl/bms_mode_ctrl.sv]
/*
 * Operating mode selection and boot ROM mapping.
 * Catches the two mode straps as reset is released, holds the expanded,
 * special and boot ROM enable bits, relocates vector fetches in special
 * modes, and tracks the bootstrap download (first character, then program).
 * Assumes straps synchronous to sys_clk, a 32-bit Avalon-MM master, and a
 * CPU that reports vector fetches and received serial characters.
 */
`timescale 1ns/1ps
module bms_mode_ctrl #(
    parameter int ROM_DEPTH = bms_pkg::BMS_ROM_BASIC,
    parameter int ROM_AW = 9
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Mode straps
    input wire logic strap_pin_a,
    input wire logic strap_pin_b,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU address path
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_vector_fetch,
    output logic [15:0] mem_addr,
    output logic boot_rom_sel,
    // Serial receive from bootstrap host
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_done,
    output logic baud_alt,
    output logic ram_we,
    output logic [7:0] ram_wdata,
    output logic [7:0] ram_waddr,
    output logic jump_to_ram
);
    import bms_pkg::*;

    typedef struct packed
    {
        logic started;
        logic expanded_select;
        logic special_select;
        logic boot_rom_enable;
        logic [ROM_AW-1:0] rom_addr;
        logic rom_rd;
        logic rom_pend;
        logic [31:0] rdata;
        logic wait_n;
        logic [15:0] mem_addr;
        logic boot_rom_sel;
        bms_boot_e boot;
        logic baud_alt;
        logic ram_we;
        logic [7:0] ram_wdata;
        logic [7:0] ram_waddr;
        logic jump;
    } bms_ctrl_s;

    bms_ctrl_s st_q;
    bms_ctrl_s st_d;

    bms_rom_if #(.AW(ROM_AW)) rom_bus ();

    bms_boot_rom #(
        .DEPTH(ROM_DEPTH),
        .AW(ROM_AW)
    ) u_rom (
        .sys_clk(sys_clk),
        .bus(rom_bus)
    );

    // Current mode from the two mode bits
    function automatic bms_mode_e mode_of(input logic exp, input logic spc);
        if (spc) // R6
            mode_of = exp ? BMS_TEST : BMS_BOOTSTRAP; // R4
        else
            mode_of = exp ? BMS_NORM_EXP : BMS_NORM_SINGLE; // R4
    endfunction

    // Full priority/mode register image
    function automatic logic [31:0] prio_image(input bms_ctrl_s s);
        prio_image = 32'h0;
        prio_image[BMS_EXP_BIT] = s.expanded_select;
        prio_image[BMS_SPC_BIT] = s.special_select;
        prio_image[BMS_BOOT_BIT] = s.boot_rom_enable;
    endfunction

    logic [15:0] rom_top;
    assign rom_top = BMS_ROM_BASE + 16'(ROM_DEPTH);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        st_d = st_q;
        st_d.rom_rd = 1'b0;
        st_d.ram_we = 1'b0;
        st_d.wait_n = 1'b0;

        // Straps are caught once, on the first clock after release
        if (!st_q.started)
        begin
            st_d.started = 1'b1;
            st_d.expanded_select = strap_pin_a; // R3
            st_d.special_select = ~strap_pin_b; // R5
            // Only bootstrap comes up with the boot ROM mapped
            st_d.boot_rom_enable = ~strap_pin_a & ~strap_pin_b; // R9
        end
        else
        begin
            // After that only software changes the mode bits
            if (avs_write && !st_q.wait_n) // R16
            begin
                st_d.wait_n = 1'b1;
                case (avs_address)
                    BMS_PRIO_OFS:
                    begin
                        if (st_q.special_select) // R7
                        begin
                            st_d.expanded_select = avs_writedata[BMS_EXP_BIT];
                            st_d.special_select = avs_writedata[BMS_SPC_BIT];
                            st_d.boot_rom_enable = avs_writedata[BMS_BOOT_BIT]; // R2 R10
                        end
                    end
                    BMS_ROMADDR_OFS:
                        st_d.rom_addr = avs_writedata[ROM_AW-1:0];
                    default:
                        st_d.wait_n = 1'b1;
                endcase
            end
            else if (avs_read && !st_q.wait_n)
            begin
                case (avs_address)
                    BMS_PRIO_OFS:
                    begin
                        st_d.rdata = prio_image(st_q);
                        st_d.wait_n = 1'b1;
                    end
                    BMS_STATUS_OFS:
                    begin
                        st_d.rdata = {26'h0, st_q.jump, st_q.baud_alt,
                            st_q.boot, mode_of(st_q.expanded_select,
                            st_q.special_select)};
                        st_d.wait_n = 1'b1;
                    end
                    BMS_ROMADDR_OFS:
                    begin
                        st_d.rdata = 32'(st_q.rom_addr);
                        st_d.wait_n = 1'b1;
                    end
                    BMS_ROMDATA_OFS:
                    begin
                        // ROM data is registered: two extra cycles
                        if (!st_q.rom_pend)
                        begin
                            st_d.rom_rd = 1'b1;
                            st_d.rom_pend = 1'b1;
                        end
                        else if (!st_q.rom_rd)
                        begin
                            // Invisible unless mapped
                            st_d.rdata = st_q.boot_rom_enable
                                ? {24'h0, rom_bus.data} : 32'h0; // R1
                            st_d.rom_pend = 1'b0;
                            st_d.wait_n = 1'b1;
                        end
                    end
                    default:
                    begin
                        st_d.rdata = BMS_BAD_ADDR;
                        st_d.wait_n = 1'b1;
                    end
                endcase
            end
        end

        // Normal modes hold the enable at zero R2
        if (st_q.started && !st_d.special_select)
            st_d.boot_rom_enable = 1'b0; // R2

        // ======================================================
        // Address path
        // ======================================================
        // Vectors move from FFxx to BFxx in special modes
        st_d.mem_addr = cpu_addr;
        if (st_q.special_select && cpu_vector_fetch)
            st_d.mem_addr[14] = 1'b0; // R8 R12
        // Bootstrap vectors land in the ROM window; test goes external
        st_d.boot_rom_sel = st_q.boot_rom_enable
            && st_d.mem_addr >= BMS_ROM_BASE
            && st_d.mem_addr < rom_top; // R1 R11

        // ======================================================
        // Bootstrap download sequence
        // ======================================================
        if (mode_of(st_q.expanded_select, st_q.special_select) == BMS_BOOTSTRAP)
        begin
            case (st_q.boot)
                BMS_WAIT_FIRST:
                begin
                    if (rx_valid)
                    begin
                        // Anything but all ones means the slow rate
                        st_d.baud_alt = (rx_data != BMS_FIRST_CHAR); // R14
                        st_d.boot = BMS_LOADING;
                    end
                end
                BMS_LOADING:
                begin
                    if (rx_valid)
                    begin
                        st_d.ram_we = 1'b1; // R15
                        st_d.ram_wdata = rx_data;
                        st_d.ram_waddr = st_q.ram_waddr + 8'h01;
                    end
                    if (rx_done)
                    begin
                        st_d.boot = BMS_RUN;
                        st_d.jump = 1'b1; // R15
                    end
                end
                BMS_RUN:
                    st_d.jump = 1'b1;
                default:
                    st_d.boot = BMS_WAIT_FIRST;
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Synchronous reset; straps caught afterwards, not here
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_q <= '0;
            st_q.ram_waddr <= 8'hFF; // First byte lands at zero
        end
        else
            st_q <= st_d;
    end

    assign rom_bus.addr = st_q.rom_addr;
    assign rom_bus.rd = st_q.rom_rd;

    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = ~st_q.wait_n;
    assign mem_addr = st_q.mem_addr;
    assign boot_rom_sel = st_q.boot_rom_sel;
    assign baud_alt = st_q.baud_alt;
    assign ram_we = st_q.ram_we;
    assign ram_wdata = st_q.ram_wdata;
    assign ram_waddr = st_q.ram_waddr;
    assign jump_to_ram = st_q.jump;

endmodule

// [verif/bms_mode_ctrl_chk.sv]
/* Port checker for bms_mode_ctrl.
   Assumes one clock and a synchronous reset; bound to every instance. */
`timescale 1ns/1ps
module bms_mode_ctrl_chk
(
    // Clock and reset
    input logic sys_clk,
    input logic reset,
    // Straps and register bus
    input logic strap_pin_a,
    input logic strap_pin_b,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    // CPU path and download
    input logic [15:0] cpu_addr,
    input logic cpu_vector_fetch,
    input logic [15:0] mem_addr,
    input logic boot_rom_sel,
    input logic rx_valid,
    input logic [7:0] rx_data,
    input logic rx_done,
    input logic baud_alt,
    input logic ram_we,
    input logic [7:0] ram_wdata,
    input logic [7:0] ram_waddr,
    input logic jump_to_ram
);
    // ========
    // Mirror of the mode bits and download progress
    logic first_q, exp_q, spc_q, boot_q, got_q, done_q;
    logic [7:0] wcnt_q;
    wire boot_m = spc_q & ~exp_q;
    wire acc_w = avs_write & ~avs_waitrequest & (avs_address == 4'h0);

    // Straps count once; later only special-mode writes move the bits
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            first_q <= 1'b1;
            {exp_q, spc_q, boot_q, got_q, done_q} <= 5'h0;
            wcnt_q <= 8'h0;
        end
        else
        begin
            first_q <= 1'b0;
            if (first_q)
                {boot_q, spc_q, exp_q} <= {~strap_pin_a & ~strap_pin_b, ~strap_pin_b, strap_pin_a};
            else if (acc_w && spc_q)
                {boot_q, spc_q, exp_q} <= {avs_writedata[7] & avs_writedata[6], avs_writedata[6:5]};
            if (rx_valid && boot_m)
                got_q <= 1'b1;
            if (rx_done && got_q)
                done_q <= 1'b1;
            if (ram_we)
                wcnt_q <= wcnt_q + 8'h1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ========
    // Download steps and the priority register read
    sequence s_first;
        rx_valid && boot_m && !got_q;
    endsequence
    sequence s_byte;
        rx_valid && boot_m && got_q && !done_q;
    endsequence
    sequence s_prio_rd;
        avs_read && !avs_waitrequest && avs_address == 4'h0;
    endsequence

    AST_VEC_SPC: assert property (cpu_vector_fetch && spc_q && !first_q |=>
        mem_addr == ($past(cpu_addr) & 16'hBFFF)) else $error("vector not relocated");
    AST_VEC_NRM: assert property (!(cpu_vector_fetch && spc_q) && !first_q |=>
        mem_addr == $past(cpu_addr)) else $error("address altered");
    AST_ROM_SEL: assert property (boot_rom_sel |-> boot_q || $past(boot_q))
        else $error("boot rom selected while disabled");
    AST_PRIO_RD: assert property (s_prio_rd |-> avs_readdata[7:5] == {boot_q, spc_q, exp_q})
        else $error("mode bits wrong");
    AST_MODE_RD: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4
        |-> avs_readdata[1:0] == {spc_q, exp_q}) else $error("mode code wrong");
    AST_BAUD: assert property (s_first |=> baud_alt == ($past(rx_data) != 8'hFF))
        else $error("baud choice wrong");
    AST_RAM_WR: assert property (s_byte |=> ram_we && ram_wdata == $past(rx_data))
        else $error("ram write missing");
    AST_WADDR: assert property (ram_we |-> ram_waddr == wcnt_q)
        else $error("ram address wrong");
    AST_JUMP: assert property (rx_done && got_q |-> ##[1:2] jump_to_ram ##1 jump_to_ram)
        else $error("no jump to ram");
endmodule

bind bms_mode_ctrl bms_mode_ctrl_chk i_bms_mode_ctrl_chk (.sys_clk, .reset, .strap_pin_a,
    .strap_pin_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .cpu_addr, .cpu_vector_fetch, .mem_addr, .boot_rom_sel, .rx_valid,
    .rx_data, .rx_done, .baud_alt, .ram_we, .ram_wdata, .ram_waddr, .jump_to_ram);

// [verif/bms_host_model.sv]
/* Board straps and bootstrap host.
   Assumes characters reach the block already framed, one pulse each. */
`timescale 1ns/1ps
module bms_host_model
(
    // Clock
    input logic sys_clk,
    // Straps and received characters
    output logic strap_pin_a,
    output logic strap_pin_b,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_done
);
    // Idle lines at time zero
    initial
    begin
        {strap_pin_a, strap_pin_b, rx_valid, rx_done} = 4'h0;
        rx_data = 8'h5A;
    end

    // Strap levels; called right after an edge
    task automatic straps(input logic a, input logic b);
        strap_pin_a <= a;
        strap_pin_b <= b;
    endtask

    // One character after a random gap; the bench sends all ones first, or C0 for the alternate rate
    task automatic send(input logic [7:0] d);
        repeat ($urandom_range(1, 3)) @(posedge sys_clk);
        rx_data <= d;
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data <= ~d; // Stale data must not look valid
    endtask

    // End of download
    task automatic finish();
        @(posedge sys_clk);
        rx_done <= 1'b1;
        @(posedge sys_clk);
        rx_done <= 1'b0;
    endtask
endmodule

// [verif/bms_mode_ctrl_tb.sv]
/* Self-checking bench for bms_mode_ctrl: four modes, bus access, download.
   Assumes the checker is bound and the host model drives straps and serial. */
`timescale 1ns/1ps
module bms_mode_ctrl_tb;
    import bms_pkg::*;
    logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, cpu_vector_fetch;
    logic boot_rom_sel, baud_alt, ram_we, jump_to_ram;
    logic strap_pin_a, strap_pin_b, rx_valid, rx_done;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] cpu_addr, mem_addr;
    logic [7:0] rx_data, ram_wdata, ram_waddr;
    logic [7:0] exp_q[$];
    int mismatches, samples_checked, nwr;

    bms_mode_ctrl i_bms_mode_ctrl (.sys_clk, .reset, .strap_pin_a, .strap_pin_b,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .cpu_addr, .cpu_vector_fetch, .mem_addr, .boot_rom_sel,
        .rx_valid, .rx_data, .rx_done, .baud_alt, .ram_we, .ram_wdata, .ram_waddr,
        .jump_to_ram);
    bms_host_model i_bms_host_model (.sys_clk, .strap_pin_a, .strap_pin_b, .rx_valid,
        .rx_data, .rx_done);

    // 25 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ========
    // Compare and report
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One bus cycle; idle edge first so strobes never bounce in one step
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        check("answer", avs_waitrequest, 0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Every RAM write must carry the next downloaded byte
    always @(posedge sys_clk)
    begin
        if (ram_we === 1'b1)
        begin
            nwr++;
            check("ram_wdata", ram_wdata, exp_q.pop_front());
        end
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end

    // ========
    // Main sequence: each mode in turn, bootstrap twice (both baud rates)
    initial
    begin
        logic [1:0] m;
        logic [2:0] pr;
        logic [7:0] d;
        int n;
        void'($urandom(32'h32EE64AE));
        {reset, avs_read, avs_write, cpu_vector_fetch} = 4'h8;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        cpu_addr = 16'h0;
        for (int i = 0; i < 5; i++)
        begin
            m = (i == 4) ? 2'd2 : 2'(i);
            reset <= 1'b1;
            i_bms_host_model.straps(m[0], ~m[1]);
            repeat (4) @(posedge sys_clk);
            reset <= 1'b0;
            @(posedge sys_clk);
            i_bms_host_model.straps(~m[0], m[1]); // Late strap moves are ignored
            pr = {m == 2'd2, m};
            bus(0, BMS_PRIO_OFS, 0, rd);
            check("prio", rd[7:5], pr);
            bus(0, BMS_STATUS_OFS, 0, rd);
            check("mode", rd[1:0], m);
            cpu_addr <= 16'hFFFE;
            cpu_vector_fetch <= 1'b1;
            repeat (3) @(posedge sys_clk);
            check("vector", mem_addr, m[1] ? 16'hBFFE : 16'hFFFE);
            check("vec_rom", boot_rom_sel, m == 2'd2);
            d = 8'($urandom);
            bus(1, BMS_PRIO_OFS, {24'h0, 2'b11, m[0], d[4:0]}, rd);
            pr = m[1] ? {2'b11, m[0]} : pr;
            bus(0, BMS_PRIO_OFS, 0, rd);
            check("prio_wr", rd[7:5], pr);
            for (int k = 0; k < 2; k++)
            begin
                cpu_addr <= k ? 16'hC000 : BMS_ROM_BASE + 16'($urandom_range(0, 191));
                cpu_vector_fetch <= 1'($urandom);
                repeat (3) @(posedge sys_clk);
                check("window", boot_rom_sel, pr[2] && k == 0);
            end
            bus(1, BMS_ROMADDR_OFS, {24'h0, d}, rd);
            bus(0, BMS_ROMDATA_OFS, 0, rd);
            check("romdata", rd[7:0], pr[2] ? ((d < BMS_ROM_BASIC) ? d ^ 8'hA5 : 8'hFF) : 8'h0);
            bus(0, 4'h2, 0, rd);
            check("unmapped", rd, BMS_BAD_ADDR);
            if (m == 2'd2)
            begin
                n = $urandom_range(1, 6);
                nwr = 0;
                i_bms_host_model.send((i == 4) ? 8'hC0 : 8'hFF);
                for (int k = 0; k < n; k++)
                begin
                    d = 8'($urandom);
                    exp_q.push_back(d);
                    i_bms_host_model.send(d);
                end
                i_bms_host_model.finish();
                repeat (3) @(posedge sys_clk);
                check("baud", baud_alt, i == 4);
                check("writes", nwr, n);
                check("jump", jump_to_ram, 1);
            end
        end
        final_report();
    end
endmodule
